// ==== rtl/edge_counter.sv ====
`timescale 1ns/1ps
`include "edge_counter_map.svh"
module edge_counter
	import edge_counter_pkg::*;
(
	input wire logic hclk, // System clock, 40 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic hready, // Bus ready in.
	input wire logic [31:0] hwdata, // Write data.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready, always high.
	output logic hresp, // Response, always OKAY.
	input wire logic source, // Source signal to count.
	input wire logic gate, // Gate or pause trigger.
	input wire logic aux_b, // Direction input B.
	input wire logic sample_clk, // Routed sample clock.
	output logic [31:0] dma_data, // Captured sample to DMA.
	output logic dma_valid, // Sample available.
	input wire logic dma_ready, // DMA accepts the sample.
	output logic overrun // Overrun flag: a push onto an unread sample, or, in hardware single-point mode only, a sample clock edge with no new pulse.
);
	state_t r;
	state_t next_r;
	mode_t mode;
	dir_t dir;
	logic armed;
	logic src_edge;
	logic smp_edge;
	logic gate_active;
	logic prev_active;
	logic paused;
	logic count_en;
	logic push;
	logic [31:0] push_data;
	logic wr_ctrl;
	logic rd_sample;
	logic pw_complete; // A measured pulse ends in this cycle.
	logic ovr_event; // Some cause sets the overrun flag in this cycle.

	// Decode control fields and detect edges on the routed inputs.
	always_comb begin
		mode = mode_t'(r.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
		dir = dir_t'(r.ctrl[`CTRL_DIR_HI:`CTRL_DIR_LO]);
		armed = r.ctrl[`CTRL_ARM];
		src_edge = r.ctrl[`CTRL_SRC_FALL] ? (r.prev.source & ~source) : (~r.prev.source & source);
		smp_edge = r.ctrl[`CTRL_SCLK_FALL] ? (r.prev.sample_clk & ~sample_clk)
			: (~r.prev.sample_clk & sample_clk);
		gate_active = gate ^ r.ctrl[`CTRL_GATE_POL];
		prev_active = r.prev.gate ^ r.ctrl[`CTRL_GATE_POL];
		paused = r.ctrl[`CTRL_PAUSE_EN] & gate_active;
		wr_ctrl = r.dp_sel & r.dp_write & (r.dp_addr == `REG_CTRL);
		rd_sample = hsel & hready & htrans[1] & ~hwrite & (haddr[7:0] == `REG_SAMPLE);
	end

	// Counting, capture and the bus slave, all in one next-state process.
	always_comb begin
		next_r = r;
		next_r.prev = '{source: source, gate: gate, aux_b: aux_b, sample_clk: sample_clk};
		count_en = 1'b0;
		push = 1'b0;
		push_data = r.count;
		pw_complete = 1'b0;
		ovr_event = 1'b0;
		if (armed) begin
			case (mode)
				MODE_EDGE_DEMAND: begin
					count_en = ~paused;
				end
				MODE_EDGE_SAMPLED: begin
					count_en = ~paused;
					push = smp_edge;
				end
				MODE_PW_SINGLE, MODE_PW_IMPLICIT, MODE_PW_SAMPLED, MODE_PW_HW_SINGLE_POINT: begin
					case (r.pw)
						PW_WAIT_IDLE: begin
							if (!gate_active) begin
								next_r.pw = PW_WAIT_START;
							end
						end
						PW_WAIT_START: begin
							if (gate_active && !prev_active) begin
								next_r.pw = PW_MEASURE;
								next_r.count = 32'h0000_0000;
							end
						end
						PW_MEASURE: begin
							if (!gate_active) begin
								pw_complete = 1'b1;
								next_r.last_width = r.count;
								next_r.last_valid = 1'b1;
								if (mode == MODE_PW_SINGLE) begin
									push = 1'b1;
									next_r.pw = PW_STOPPED;
									next_r.done = 1'b1;
								end else begin
									push = (mode == MODE_PW_IMPLICIT);
									next_r.pw = PW_WAIT_START;
								end
							end else begin
								count_en = 1'b1;
							end
						end
						PW_STOPPED: begin
							count_en = 1'b0;
						end
						default: begin
							next_r.pw = PW_WAIT_IDLE;
						end
					endcase
					if ((mode == MODE_PW_SAMPLED || mode == MODE_PW_HW_SINGLE_POINT) && smp_edge) begin
						push = 1'b1;
						// A pulse that ends on the sample edge itself is the latest one, so it is sent now.
						push_data = pw_complete ? r.count : r.last_width;
						next_r.last_valid = 1'b0;
						if (mode == MODE_PW_HW_SINGLE_POINT && !r.last_valid && !pw_complete) begin
							next_r.overrun = 1'b1;
							ovr_event = 1'b1;
						end
					end
				end
				default: begin
					count_en = 1'b0;
				end
			endcase
		end
		// Count update with selectable direction; arithmetic wraps naturally.
		if (count_en && src_edge) begin
			if (dir == DIR_DOWN || (dir == DIR_BY_AUX && !aux_b)) begin
				next_r.count = r.count - 32'h0000_0001;
			end else begin
				next_r.count = r.count + 32'h0000_0001;
			end
		end
		// One-entry output register toward the DMA; a new push overwrites a stale one.
		if (dma_valid && dma_ready) begin
			next_r.fifo_valid = 1'b0;
		end
		if (push) begin
			if (r.fifo_valid && !dma_ready) begin
				next_r.overrun = 1'b1;
				ovr_event = 1'b1;
			end
			next_r.fifo_data = push_data;
			next_r.fifo_valid = 1'b1;
		end else if (rd_sample && r.fifo_valid) begin
			next_r.fifo_valid = 1'b0;
		end
		// Address phase capture.
		next_r.dp_sel = hsel & hready & htrans[1];
		if (hsel && hready && htrans[1]) begin
			next_r.dp_write = hwrite;
			next_r.dp_addr = haddr[7:0];
			case (haddr[7:0])
				`REG_CTRL: next_r.rdata = r.ctrl;
				`REG_COUNT: next_r.rdata = r.count;
				`REG_STATUS: next_r.rdata = {28'h000_0000, r.fifo_valid & ~push, 1'b0, r.done, r.overrun};
				`REG_SAMPLE: next_r.rdata = r.fifo_data;
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
		// Data phase write. Writing control with ARM set while disarmed rearms; a status write of bit 0 clears overrun unless it is set that cycle.
		if (wr_ctrl) begin
			next_r.ctrl = hwdata;
			if (hwdata[`CTRL_ARM] && !armed) begin
				next_r.count = 32'h0000_0000;
				next_r.pw = PW_WAIT_IDLE;
				next_r.last_valid = 1'b0;
				next_r.done = 1'b0;
			end
		end
		if (r.dp_sel && r.dp_write && r.dp_addr == `REG_STATUS && hwdata[`STAT_OVERRUN]
			&& !ovr_event) begin
			next_r.overrun = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Output assignments.
	always_comb begin
		hrdata = r.rdata;
		hreadyout = 1'b1;
		hresp = 1'b0;
		dma_data = r.fifo_data;
		dma_valid = r.fifo_valid;
		overrun = r.overrun;
	end
endmodule : edge_counter

// ==== rtl/edge_counter_map.svh ====
`ifndef EDGE_COUNTER_MAP_SVH
`define EDGE_COUNTER_MAP_SVH
// Register byte offsets on the AHB-Lite slave.
`define REG_CTRL 8'h00
`define REG_COUNT 8'h04
`define REG_STATUS 8'h08
`define REG_SAMPLE 8'h0C
// Control register fields.
`define CTRL_ARM 0
`define CTRL_SRC_FALL 1
`define CTRL_GATE_POL 2
`define CTRL_SCLK_FALL 3
`define CTRL_DIR_LO 4
`define CTRL_DIR_HI 5
`define CTRL_MODE_LO 8
`define CTRL_MODE_HI 10
`define CTRL_PAUSE_EN 11
// Status register fields.
`define STAT_OVERRUN 0
`define STAT_DONE 1
`define STAT_FIFO_VALID 2
`define STAT_FIFO_FULL 3
`define CTRL_RESET 32'h0000_0000
`endif

// ==== rtl/edge_counter_pkg.sv ====
package edge_counter_pkg;
	// Measurement mode encoding held in the control register.
	typedef enum logic [2:0] {
		MODE_EDGE_DEMAND = 3'h0,
		MODE_EDGE_SAMPLED = 3'h1,
		MODE_PW_SINGLE = 3'h2,
		MODE_PW_IMPLICIT = 3'h3,
		MODE_PW_SAMPLED = 3'h4,
		MODE_PW_HW_SINGLE_POINT = 3'h5
	} mode_t;
	// Count direction selection.
	typedef enum logic [1:0] {
		DIR_UP = 2'h0,
		DIR_DOWN = 2'h1,
		DIR_BY_AUX = 2'h2
	} dir_t;
	// Pulse-width measurement phase.
	typedef enum logic [1:0] {
		PW_WAIT_IDLE,
		PW_WAIT_START,
		PW_MEASURE,
		PW_STOPPED
	} pw_state_t;
	// Inputs coming from routed signals.
	typedef struct packed {
		logic source;
		logic gate;
		logic aux_b;
		logic sample_clk;
	} pins_t;
	// Whole state of the counter block.
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] count;
		logic [31:0] last_width;
		logic last_valid;
		pw_state_t pw;
		pins_t prev;
		logic [31:0] fifo_data;
		logic fifo_valid;
		logic overrun;
		logic done;
		logic dp_sel;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} state_t;
endpackage : edge_counter_pkg

// ==== tb/edge_counter_assertions.sv ====
`timescale 1ns/1ps
module edge_counter_checker (
	input wire logic hclk, hresetn, hsel, hready, hreadyout, hresp, // Bus control.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic [31:0] hrdata, dma_data, // Read data and sample.
	input wire logic gate, sample_clk, dma_valid, dma_ready, overrun // Events and stream.
);
	logic ta_d;
	logic [2:0] q;
	logic ta;
	// An address phase is taken at this edge; a sample read pops at this same edge.
	assign ta = hsel && hready && htrans[1];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Note a taken address phase, and cycles since gate or sample clock last moved.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ta_d <= 1'b0;
			q <= 3'h0;
		end else begin
			ta_d <= ta;
			q <= $changed({gate, sample_clk}) ? 3'h0 : q + {2'h0, q != 3'h7};
		end
	end
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus not ready");
	property p_hrd; !ta_d |-> $stable(hrdata); endproperty
	a_hrd: assert property (p_hrd) else $error("read data moved");
	property p_keep; dma_valid && !dma_ready && !ta |=> dma_valid; endproperty
	a_keep: assert property (p_keep) else $error("sample lost");
	property p_fall; $fell(dma_valid) |-> $past(dma_ready) || ta_d; endproperty
	a_fall: assert property (p_fall) else $error("sample dropped");
	property p_rise; $rose(dma_valid) |-> q < 3'h5; endproperty
	a_rise: assert property (p_rise) else $error("sample without event");
	property p_data; dma_valid && q > 3'h4 |-> $stable(dma_data); endproperty
	a_data: assert property (p_data) else $error("sample changed");
	property p_ovr; overrun && !ta_d |=> overrun; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun lost");
	property p_ovrr; $rose(overrun) |-> q < 3'h5; endproperty
	a_ovrr: assert property (p_ovrr) else $error("overrun without event");
endmodule : edge_counter_checker
bind edge_counter edge_counter_checker chk_i (.*);

// ==== tb/signal_source.sv ====
`timescale 1ns/1ps
module signal_source (
	input wire logic clk, // System clock.
	input wire logic load, // Start a run.
	input wire logic [7:0] n, // Toggles in the run.
	input wire logic [2:0] lvl, // Gate, B, sample clock.
	output logic source = 1'b0, // Timebase, still between runs.
	output logic gate = 1'b0, // Gate level.
	output logic aux_b = 1'b0, // Direction level.
	output logic sample_clk = 1'b0, // Sample clock level.
	output logic busy // Run in progress.
);
	logic [7:0] left = 8'h00;
	assign busy = left != 8'h00;
	// Levels follow a cycle late; the timebase toggles once a cycle during a run.
	always @(posedge clk) begin
		{gate, aux_b, sample_clk} <= lvl;
		if (load) begin
			left <= n;
		end else if (busy) begin
			left <= left - 8'h01;
			source <= !source;
		end
	end
endmodule : signal_source

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import edge_counter_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, load = 1'b0, dma_ready = 1'b0;
	logic src = 1'b0, sf = 1'b0, hreadyout, hresp, source, gate, aux_b, sample_clk, dma_valid;
	logic overrun, busy, fl, pol, pz, ab, g;
	logic [1:0] htrans = 2'h0, d;
	logic [2:0] hsize = 3'h2, lvl = 3'h0;
	logic [7:0] n = 8'h00, k;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dma_data, r, e, acc;
	int n_fail = 0, comparisons = 0, cyc = 0, seed = 46313;
	edge_counter dut (.hready(hreadyout), .*);
	signal_source partner (.clk(hclk), .*);
	initial forever #12.5 hclk = !hclk;
	// Cut a hang short.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= x;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	// Run the timebase with a count read in mid-run, then let things settle.
	task automatic drive(input logic [7:0] t, input logic [2:0] l);
		n <= t;
		lvl <= l;
		load <= 1'b1;
		@(posedge hclk);
		load <= 1'b0;
		bus(1'b0, 8'h04, 32'h0);
		while (busy) @(posedge hclk);
		repeat (4) @(posedge hclk);
		src = src ^ t[0];
	endtask : drive
	task automatic pop(input logic v, input logic [31:0] x);
		chk({31'h0, dma_valid}, {31'h0, v});
		if (v) chk(dma_data, x);
		dma_ready <= 1'b1;
		@(posedge hclk);
		dma_ready <= 1'b0;
		@(posedge hclk);
	endtask : pop
	task automatic arm_with(input logic [2:0] md);
		bus(1'b1, 8'h00, {20'h0, pz, md, 2'h0, d, sf, pol, fl, 1'b0});
		bus(1'b1, 8'h00, {20'h0, pz, md, 2'h0, d, sf, pol, fl, 1'b1});
	endtask : arm_with
	function automatic logic [31:0] edges(input logic [7:0] t);
		return {24'h0, (t + {7'h0, !(src ^ fl)}) >> 1};
	endfunction : edges
	// Reset, then demand counting, sampled counting and pulse widths.
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h10, 32'h0);
		chk(r, 32'h0);
		drive(8'h05, 3'h0);
		chk(r, 32'h0);
		repeat (12) begin
			{fl, pol, pz, ab, g} = 5'($random(seed));
			d = 2'({$random(seed)} % 3);
			k = 8'($random(seed)) & 8'h3F;
			drive(8'h00, {g, ab, 1'b0});
			arm_with(MODE_EDGE_DEMAND);
			e = (pz && (g ^ pol)) ? 32'h0 : edges(k);
			drive(k, {g, ab, 1'b0});
			bus(1'b0, 8'h04, 32'h0);
			chk(r, (d == 2'h1 || (d == 2'h2 && !ab)) ? -e : e);
		end
		{pz, d} = 3'h0;
		repeat (2) begin
			sf = !sf;
			arm_with(MODE_EDGE_SAMPLED);
			acc = 32'h0;
			repeat (3) begin
				k = 8'($random(seed)) & 8'h3F;
				acc += edges(k);
				drive(k, 3'h0);
				drive(8'h00, 3'h1);
				chk({31'h0, dma_valid}, {31'h0, !sf});
				drive(8'h00, 3'h0);
				pop(1'b1, acc);
			end
		end
		for (int i = 2; i < 6; i++) begin
			pol = i[0];
			drive(8'h00, {!pol, 2'h0});
			arm_with(3'(i));
			drive(8'h07, {!pol, 2'h0});
			drive(8'h09, {pol, 2'h0});
			chk({31'h0, dma_valid}, 32'h0);
			k = 8'($random(seed)) & 8'h3F;
			drive(8'h00, {!pol, 2'h0});
			e = edges(k);
			drive(k, {!pol, 2'h0});
			drive(8'h00, {pol, 2'h0});
			pop(i < 4, e);
			drive(8'h00, {pol, 2'h1});
			drive(8'h00, {pol, 2'h0});
			pop(i > 3, e);
			drive(8'h00, {pol, 2'h1});
			drive(8'h00, {pol, 2'h0});
			chk({31'h0, overrun}, {31'h0, i == 5});
			pop(i > 3, e);
			drive(8'h00, {!pol, 2'h0});
			e = edges(8'h05);
			drive(8'h05, {!pol, 2'h0});
			drive(8'h00, {pol, 2'h0});
			pop(i == 3, e);
			bus(1'b1, 8'h08, 32'h1);
			@(posedge hclk);
			chk({31'h0, overrun}, 32'h0);
		end
		close_out();
	end
endmodule : testbench
